//--- logic/rbf_byte_fifo.sv
// One byte FIFO with fill count and optional last-byte read hazard.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/100ps
module rbf_byte_fifo #(
  parameter int DEPTH      = rbf_pkg::FIFO_DEPTH,
  parameter int WIDTH      = rbf_pkg::BYTE_W,
  parameter bit DUP_HAZARD = 1'b0
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  flush,
  input  wire logic                  push,
  input  wire logic [WIDTH-1:0]      din,
  input  wire logic                  pop,
  output logic      [WIDTH-1:0]      dout,
  output rbf_pkg::rbf_fifo_stat_s    stat
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [rbf_pkg::CNT_W-1:0] FULL_CNT =
    rbf_pkg::CNT_W'(DEPTH);
  localparam logic [rbf_pkg::CNT_W-1:0] ONE_CNT = 7'h01;

  logic [WIDTH-1:0]          mem [DEPTH];
  logic [AW-1:0]             wr_ff, nxt_wr;
  logic [AW-1:0]             rd_ff, nxt_rd;
  logic [rbf_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic                      do_pop;
  logic                      stuck;

  // ----------------------------------------------------------------
  // Pointers and count
  // ----------------------------------------------------------------
  always_comb begin
    do_pop  = pop && (cnt_ff != '0);
    // Write meeting the read of the last byte leaves rd behind
    stuck   = DUP_HAZARD && push && do_pop && (cnt_ff == ONE_CNT);
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      // No guard on full: the oldest entry is overwritten
      nxt_wr = wr_ff + 1'b1;
    end
    if (do_pop && !stuck) begin
      nxt_rd = rd_ff + 1'b1;
    end
    if (push && !do_pop && (cnt_ff != FULL_CNT)) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (do_pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
    if (flush) begin
      nxt_wr  = '0;
      nxt_rd  = '0;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge mclk) begin
    if (push && !flush) begin
      mem[wr_ff] <= din;
    end
  end

  // Read past empty shows a stale entry
  assign dout       = mem[rd_ff];
  assign stat.count = cnt_ff;
  assign stat.full  = (cnt_ff == FULL_CNT);
  assign stat.empty = (cnt_ff == '0);

endmodule : rbf_byte_fifo

//--- logic/rbf_fifo_pair.sv
// Receive and transmit byte FIFO pair with APB register port.
// Assumes an APB master on mclk and a serial radio link whose
// clock is sampled here as an ordinary asynchronous input.
//
// Overview of operation
// - Two separate 64-entry byte FIFOs exist, one for receive and one for transmit.
// - The host only reads the receive FIFO and writes the transmit FIFO; the radio fills and drains them.
// - Receive overflow and transmit underflow are both detected.
// - A status byte with the receive fill on receive data reads and transmit fill on transmit data writes is latched; receive data reads also return it.
// - Both FIFO byte counts are readable as separate status values.
// - A receive write meeting the read of the last byte stalls the read pointer and repeats that byte.
// - A 4-bit threshold select gives 16 settings for both FIFOs.
// - Setting k gives a receive threshold of 4(k+1) and a transmit threshold of 61-4k bytes.
// - A threshold signal is high while the count is at or above threshold and can drive the output pins.
// - Entering sleep discards the contents of both FIFOs.
`timescale 1ns/100ps
module rbf_fifo_pair (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [rbf_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       lnk_clk,
  input  wire logic                       lnk_rx_frame,
  input  wire logic                       lnk_rx_bit,
  input  wire logic                       lnk_tx_frame,
  output logic                            lnk_tx_bit,
  output logic      [rbf_pkg::PIN_N-1:0]  general_output_pins,
  output logic                            irq
);
  localparam int CW = rbf_pkg::CNT_W;
  localparam int BW = rbf_pkg::BYTE_W;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == rbf_pkg::OFS_CTRL)   || (a == rbf_pkg::OFS_RXCNT)
              || (a == rbf_pkg::OFS_TXCNT)  || (a == rbf_pkg::OFS_RXDATA)
              || (a == rbf_pkg::OFS_TXDATA) || (a == rbf_pkg::OFS_STBYTE)
              || (a == rbf_pkg::OFS_IRQ_STAT)
              || (a == rbf_pkg::OFS_IRQ_MASK);
  endfunction : addr_known

  function automatic logic [3:0] fill_clip(input logic [CW-1:0] c);
    fill_clip = (c > CW'(rbf_pkg::FILL_CLIP)) ? rbf_pkg::FILL_CLIP
                                              : c[3:0];
  endfunction : fill_clip

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0]                    sync1_ff, sync2_ff;
  logic                          clk_dly_ff;
  logic                          lnk_rise, lnk_fall;
  logic [rbf_pkg::CTRL_W-1:0]    ctrl_ff, nxt_ctrl;
  logic [rbf_pkg::IRQ_W-1:0]     stat_ff, nxt_stat;
  logic [rbf_pkg::IRQ_W-1:0]     mask_ff, nxt_mask;
  logic [rbf_pkg::IRQ_W-1:0]     events;
  logic [31:0]                   prdata_ff, nxt_prdata;
  logic                          pready_ff, nxt_pready;
  logic                          pslverr_ff, nxt_pslverr;
  logic [7:0]                    stbyte_ff, nxt_stbyte;
  logic                          irq_ff, nxt_irq;
  logic [rbf_pkg::PIN_N-1:0]     pins_ff, nxt_pins;
  logic                          rx_thr_ff, nxt_rx_thr;
  logic                          tx_thr_ff, nxt_tx_thr;
  logic [BW-1:0]                 rx_sh_ff, nxt_rx_sh;
  logic [2:0]                    rx_bits_ff, nxt_rx_bits;
  logic [BW-1:0]                 tx_sh_ff, nxt_tx_sh;
  logic [2:0]                    tx_bits_ff, nxt_tx_bits;
  logic                          tx_bit_ff, nxt_tx_bit;
  logic                          lnk_rx_s1_ff, lnk_rx_s2_ff;
  rbf_pkg::rbf_lnk_e             lnk_st_ff, nxt_lnk_st;
  logic                          setup, done, hit;
  logic                          rx_push, rx_pop, tx_push, tx_pop;
  logic                          flush;
  logic [BW-1:0]                 rx_din, rx_dout, tx_dout;
  logic [CW-1:0]                 rx_thr, tx_thr;
  logic [rbf_pkg::THR_W-1:0]     thr_sel;
  rbf_pkg::rbf_fifo_stat_s       rx_st, tx_st;

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  rbf_byte_fifo #(.DEPTH(rbf_pkg::FIFO_DEPTH), .WIDTH(BW),
                  .DUP_HAZARD(1'b1)) u_rx_fifo (
    .mclk  (mclk),
    .rst_n (rst_n),
    .flush (flush),
    .push  (rx_push),
    .din   (rx_din),
    .pop   (rx_pop),
    .dout  (rx_dout),
    .stat  (rx_st)
  );

  rbf_byte_fifo #(.DEPTH(rbf_pkg::FIFO_DEPTH), .WIDTH(BW),
                  .DUP_HAZARD(1'b0)) u_tx_fifo (
    .mclk  (mclk),
    .rst_n (rst_n),
    .flush (flush),
    .push  (tx_push),
    .din   (pwdata[BW-1:0]),
    .pop   (tx_pop),
    .dout  (tx_dout),
    .stat  (tx_st)
  );

  // ----------------------------------------------------------------
  // Link input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_ff   <= '0;
      sync2_ff   <= '0;
      clk_dly_ff <= 1'b0;
    end else begin
      sync1_ff   <= {lnk_tx_frame, lnk_rx_frame, lnk_clk};
      sync2_ff   <= sync1_ff;
      clk_dly_ff <= sync2_ff[0];
    end
  end

  assign lnk_rise = sync2_ff[0] && !clk_dly_ff;
  assign lnk_fall = !sync2_ff[0] && clk_dly_ff;

  // ----------------------------------------------------------------
  // APB decode and FIFO access
  // ----------------------------------------------------------------
  assign setup   = psel && !penable && !pready_ff;
  assign done    = psel && penable && pready_ff;
  assign hit     = addr_known(paddr);
  // Host only reads receive data and only writes transmit data
  assign rx_pop  = done && !pwrite && (paddr == rbf_pkg::OFS_RXDATA);
  assign tx_push = done && pwrite && (paddr == rbf_pkg::OFS_TXDATA);
  // Sleep keeps both FIFOs empty until it is left again
  assign flush   = ctrl_ff[rbf_pkg::SLEEP_BIT] || nxt_ctrl[rbf_pkg::SLEEP_BIT];
  assign thr_sel = ctrl_ff[rbf_pkg::THR_LSB +: rbf_pkg::THR_W];

  always_comb begin
    nxt_pready  = setup;
    nxt_pslverr = setup && !hit;
    nxt_prdata  = '0;
    nxt_stbyte  = stbyte_ff;
    if (setup && !pwrite) begin
      case (paddr)
        rbf_pkg::OFS_CTRL:     nxt_prdata = 32'(ctrl_ff);
        rbf_pkg::OFS_RXCNT:    nxt_prdata = 32'(rx_st.count);
        rbf_pkg::OFS_TXCNT:    nxt_prdata = 32'(tx_st.count);
        rbf_pkg::OFS_RXDATA:   nxt_prdata = {16'h0000,
                                 1'b0, ctrl_ff[rbf_pkg::SLEEP_BIT], 2'b00,
                                 fill_clip(rx_st.count), rx_dout};
        rbf_pkg::OFS_STBYTE:   nxt_prdata = 32'(stbyte_ff);
        rbf_pkg::OFS_IRQ_STAT: nxt_prdata = 32'(stat_ff);
        rbf_pkg::OFS_IRQ_MASK: nxt_prdata = 32'(mask_ff);
        default:               nxt_prdata = '0;
      endcase
    end
    // Status byte taken while the access is being set up
    if (setup && !pwrite && (paddr == rbf_pkg::OFS_RXDATA)) begin
      nxt_stbyte = {1'b0, ctrl_ff[rbf_pkg::SLEEP_BIT], 2'b00,
                    fill_clip(rx_st.count)};
    end else if (setup && pwrite && (paddr == rbf_pkg::OFS_TXDATA)) begin
      nxt_stbyte = {1'b0, ctrl_ff[rbf_pkg::SLEEP_BIT], 2'b00,
                    fill_clip(tx_st.count)};
    end
  end

  // ----------------------------------------------------------------
  // Control, thresholds, interrupts and pins
  // ----------------------------------------------------------------
  function automatic logic pin_src(input logic [1:0] sel,
                                   input logic rxt, input logic txt,
                                   input logic ir);
    case (sel)
      rbf_pkg::PSEL_RX_THR: pin_src = rxt;
      rbf_pkg::PSEL_TX_THR: pin_src = txt;
      rbf_pkg::PSEL_IRQ:    pin_src = ir;
      default:              pin_src = 1'b0;
    endcase
  endfunction : pin_src

  always_comb begin
    rx_thr = (CW'(thr_sel) << rbf_pkg::THR_SHIFT)
           + rbf_pkg::RX_THR_BASE;
    tx_thr = rbf_pkg::TX_THR_BASE
           - (CW'(thr_sel) << rbf_pkg::THR_SHIFT);
    // Level compare, so rx_thr_ff falls one cycle after the count does
    nxt_rx_thr = (rx_st.count >= rx_thr);
    nxt_tx_thr = (tx_st.count >= tx_thr);
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    if (done && pwrite && (paddr == rbf_pkg::OFS_CTRL)) begin
      nxt_ctrl = pwdata[rbf_pkg::CTRL_W-1:0];
    end
    if (done && pwrite && (paddr == rbf_pkg::OFS_IRQ_MASK)) begin
      nxt_mask = pwdata[rbf_pkg::IRQ_W-1:0];
    end
    events = '0;
    events[rbf_pkg::IRQ_RX_OVF] = rx_st.full && (rx_push || (lnk_rise
      && sync2_ff[1] && (rx_bits_ff == rbf_pkg::LAST_BIT)));
    events[rbf_pkg::IRQ_TX_UDF] = lnk_fall && sync2_ff[2]
      && (tx_bits_ff == '0) && tx_st.empty;
    events[rbf_pkg::IRQ_RX_THR] = nxt_rx_thr && !rx_thr_ff;
    events[rbf_pkg::IRQ_TX_THR] = nxt_tx_thr && !tx_thr_ff;
    // A new event wins over a write-one clear in the same cycle
    nxt_stat = stat_ff;
    if (done && pwrite && (paddr == rbf_pkg::OFS_IRQ_STAT)) begin
      nxt_stat = stat_ff & ~pwdata[rbf_pkg::IRQ_W-1:0];
    end
    nxt_stat = nxt_stat | events;
    nxt_irq  = |(nxt_stat & nxt_mask);
    for (int i = 0; i < rbf_pkg::PIN_N; i++) begin
      nxt_pins[i] = pin_src(ctrl_ff[rbf_pkg::PSEL_LSB
                      + i*rbf_pkg::PSEL_W +: rbf_pkg::PSEL_W],
                      rx_thr_ff, tx_thr_ff, irq_ff);
    end
  end

  // ----------------------------------------------------------------
  // Radio link shifters
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rx_sh   = rx_sh_ff;
    nxt_rx_bits = rx_bits_ff;
    rx_push     = 1'b0;
    rx_din      = {rx_sh_ff[BW-2:0], sync2_ff[0]};
    if (!sync2_ff[1]) begin
      nxt_rx_bits = '0;
    end else if (lnk_rise) begin
      nxt_rx_sh   = {rx_sh_ff[BW-2:0], lnk_rx_s2_ff};
      rx_din      = {rx_sh_ff[BW-2:0], lnk_rx_s2_ff};
      nxt_rx_bits = rx_bits_ff + 1'b1;
      // Radio fills the receive FIFO; a byte meeting a full FIFO is lost
      rx_push     = (rx_bits_ff == rbf_pkg::LAST_BIT) && !rx_st.full;
    end
    nxt_lnk_st  = sync2_ff[2] ? rbf_pkg::LNK_SHIFT : rbf_pkg::LNK_IDLE;
    nxt_tx_sh   = tx_sh_ff;
    nxt_tx_bits = tx_bits_ff;
    nxt_tx_bit  = tx_bit_ff;
    tx_pop      = 1'b0;
    case (lnk_st_ff)
      rbf_pkg::LNK_IDLE: begin
        nxt_tx_bits = '0;
        nxt_tx_bit  = 1'b0;
      end
      rbf_pkg::LNK_SHIFT: begin
        if (lnk_fall) begin
          nxt_tx_bits = tx_bits_ff + 1'b1;
          if (tx_bits_ff == '0) begin
            // Radio drains the transmit FIFO; empty sends zeros
            tx_pop      = !tx_st.empty;
            nxt_tx_sh   = tx_st.empty ? '0 : {tx_dout[BW-2:0], 1'b0};
            nxt_tx_bit  = tx_st.empty ? 1'b0 : tx_dout[BW-1];
          end else begin
            nxt_tx_bit  = tx_sh_ff[BW-1];
            nxt_tx_sh   = {tx_sh_ff[BW-2:0], 1'b0};
          end
        end
      end
      default: nxt_tx_bits = '0;
    endcase
  end

  // Receive data bit sampled through its own synchroniser pair
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lnk_rx_s1_ff <= 1'b0;
      lnk_rx_s2_ff <= 1'b0;
    end else begin
      lnk_rx_s1_ff <= lnk_rx_bit;
      lnk_rx_s2_ff <= lnk_rx_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_ff    <= rbf_pkg::CTRL_RST;
      mask_ff    <= rbf_pkg::MASK_RST;
      stat_ff    <= '0;
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      stbyte_ff  <= '0;
      irq_ff     <= 1'b0;
      pins_ff    <= '0;
      rx_thr_ff  <= 1'b0;
      tx_thr_ff  <= 1'b0;
      rx_sh_ff   <= '0;
      rx_bits_ff <= '0;
      tx_sh_ff   <= '0;
      tx_bits_ff <= '0;
      tx_bit_ff  <= 1'b0;
      lnk_st_ff  <= rbf_pkg::LNK_IDLE;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      mask_ff    <= nxt_mask;
      stat_ff    <= nxt_stat;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      stbyte_ff  <= nxt_stbyte;
      irq_ff     <= nxt_irq;
      pins_ff    <= nxt_pins;
      rx_thr_ff  <= nxt_rx_thr;
      tx_thr_ff  <= nxt_tx_thr;
      rx_sh_ff   <= nxt_rx_sh;
      rx_bits_ff <= nxt_rx_bits;
      tx_sh_ff   <= nxt_tx_sh;
      tx_bits_ff <= nxt_tx_bits;
      tx_bit_ff  <= nxt_tx_bit;
      lnk_st_ff  <= nxt_lnk_st;
    end
  end

  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign lnk_tx_bit          = tx_bit_ff;
  assign general_output_pins = pins_ff;
  assign irq                 = irq_ff;

endmodule : rbf_fifo_pair

//--- logic/rbf_fifo_pair_fix.sv
// Holds no logic: the FIFO pair and its byte FIFO have files of their own.

//--- shared/rbf_pkg.sv
// Constants and carrier types for the radio byte FIFO pair.
// Assumes a single core clock and an APB register port.
package rbf_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 64;
  localparam int BYTE_W     = 8;
  localparam int CNT_W      = 7;
  localparam int ADDR_W     = 8;
  localparam int THR_W      = 4;
  localparam int PIN_N      = 2;
  localparam int PSEL_W     = 2;
  localparam int IRQ_W      = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_RXCNT    = 8'h08;
  localparam logic [7:0] OFS_TXCNT    = 8'h0c;
  localparam logic [7:0] OFS_RXDATA   = 8'h10;
  localparam logic [7:0] OFS_TXDATA   = 8'h14;
  localparam logic [7:0] OFS_STBYTE   = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int THR_LSB   = 0;
  localparam int SLEEP_BIT = 4;
  localparam int PSEL_LSB  = 8;
  localparam int CTRL_W    = 12;
  localparam logic [11:0] CTRL_RST = 12'h400;
  localparam logic [3:0]  MASK_RST = 4'h0;
  localparam int STB_SLEEP_BIT = 6;

  // Output pin signal selections
  localparam logic [1:0] PSEL_RX_THR = 2'h0;
  localparam logic [1:0] PSEL_TX_THR = 2'h1;
  localparam logic [1:0] PSEL_IRQ    = 2'h2;

  // Interrupt status bits
  localparam int IRQ_RX_OVF = 0;
  localparam int IRQ_TX_UDF = 1;
  localparam int IRQ_RX_THR = 2;
  localparam int IRQ_TX_THR = 3;

  // ----------------------------------------------------------------
  // Threshold coding
  // ----------------------------------------------------------------
  localparam logic [6:0] RX_THR_BASE = 7'h04;
  localparam logic [6:0] TX_THR_BASE = 7'h3d;
  localparam int         THR_SHIFT   = 2;
  localparam logic [3:0] FILL_CLIP   = 4'hf;

  // Link bit counter wraps after a byte
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             full;
    logic             empty;
  } rbf_fifo_stat_s;

  typedef enum logic {LNK_IDLE, LNK_SHIFT} rbf_lnk_e;

endpackage : rbf_pkg

//--- verif/rbf_fifo_pair_asserts.sv
// Port checker for the radio byte FIFO pair.
// Assumes one core clock and the bind at the foot of this file.
`timescale 1ns/100ps
module rbf_fifo_pair_chk (
  input wire logic                       mclk,
  input wire logic                       rst_n,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [rbf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       lnk_clk,
  input wire logic                       lnk_tx_frame,
  input wire logic                       lnk_tx_bit,
  input wire logic                       irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_idle; !psel |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("stray ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("lone error");
  property p_unmap;
    psel && !penable && paddr == 8'h04 |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("no error");
  property p_cnt;
    pready && !pwrite && (paddr == rbf_pkg::OFS_RXCNT ||
      paddr == rbf_pkg::OFS_TXCNT) |-> prdata <= 32'h40;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count range");
  property p_stb;
    pready && !pwrite && paddr == rbf_pkg::OFS_RXDATA |->
      prdata[31:16] == 16'h0 && !prdata[15] && prdata[13:12] == 2'h0;
  endproperty
  a_stb: assert property (p_stb) else $error("status bits");
  property p_txidle; !lnk_tx_frame [*5] |-> !lnk_tx_bit; endproperty
  a_txidle: assert property (p_txidle) else $error("tx idle");
  property p_txedge;
    $changed(lnk_tx_bit) |-> !lnk_clk || !lnk_tx_frame;
  endproperty
  a_txedge: assert property (p_txedge) else $error("tx edge");
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_tx: cover property ($rose(lnk_tx_bit));
endmodule : rbf_fifo_pair_chk

bind rbf_fifo_pair rbf_fifo_pair_chk rbf_fifo_pair_chk_i (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .lnk_clk(lnk_clk), .lnk_tx_frame(lnk_tx_frame),
  .lnk_tx_bit(lnk_tx_bit), .irq(irq));

//--- verif/rbf_radio_model.sv
// Radio side model: sends receive bytes, collects transmit bytes.
// Assumes the link clock stands low outside frames.
`timescale 1ns/100ps
module rbf_radio_model (
  output logic      lnk_clk,
  output logic      lnk_rx_frame,
  output logic      lnk_rx_bit,
  output logic      lnk_tx_frame,
  input  wire logic lnk_tx_bit
);
  localparam int HALF = 80;
  initial begin
    lnk_clk = 1'b0;
    lnk_rx_frame = 1'b0;
    lnk_rx_bit = 1'b1;
    lnk_tx_frame = 1'b0;
  end
  // Offset of 3 ns keeps link edges off the core clock edges
  task automatic rx_byte(input logic [7:0] b);
    #3 lnk_rx_frame = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      lnk_rx_bit = b[i];
      #HALF lnk_clk = 1'b1;
      #HALF lnk_clk = 1'b0;
    end
    lnk_rx_frame = 1'b0;
    lnk_rx_bit = ~b[0];
  endtask : rx_byte
  // Frame drops before the last fall so no extra byte is popped
  task automatic tx_byte(output logic [7:0] b);
    #3 lnk_tx_frame = 1'b1;
    #HALF lnk_clk = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #HALF lnk_clk = 1'b0;
      #HALF lnk_clk = 1'b1;
      b[i] = lnk_tx_bit;
    end
    #HALF lnk_tx_frame = 1'b0;
    #HALF lnk_clk = 1'b0;
  endtask : tx_byte
endmodule : rbf_radio_model

//--- verif/testbench.sv
// Self-checking bench: APB host tasks and a radio link model.
// Assumes the package constants for the register map.
`timescale 1ns/100ps
module testbench;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        lnk_clk, lnk_rx_frame, lnk_rx_bit, lnk_tx_frame, lnk_tx_bit;
  logic        irq;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  pins;
  int          error_cnt, cmp_count;
  rbf_fifo_pair rbf_fifo_pair_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk_clk(lnk_clk),
    .lnk_rx_frame(lnk_rx_frame), .lnk_rx_bit(lnk_rx_bit),
    .lnk_tx_frame(lnk_tx_frame), .lnk_tx_bit(lnk_tx_bit),
    .general_output_pins(pins), .irq(irq));
  rbf_radio_model rbf_radio_model_i (.lnk_clk(lnk_clk),
    .lnk_rx_frame(lnk_rx_frame), .lnk_rx_bit(lnk_rx_bit),
    .lnk_tx_frame(lnk_tx_frame), .lnk_tx_bit(lnk_tx_bit));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // One idle cycle after each transfer keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        conclude();
      end
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic sweep(input int tn, input int rn);
    for (int k = 0; k < 16; k++) begin
      apb(1'b1, rbf_pkg::OFS_CTRL, 32'h100 | k);
      repeat (3) @(posedge mclk);
      chk(pins[0], tn >= 61 - 4 * k);
      chk(pins[1], rn >= 4 * k + 4);
    end
  endtask : sweep
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk(pins, 2'h0);
    apb(1'b0, rbf_pkg::OFS_CTRL, 0);
    chk(rd, 32'h400);
    apb(1'b0, rbf_pkg::OFS_IRQ_MASK, 0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 0);
    chk(err, 1'b1);
    $display("reset and map test done");
    for (int n = 1; n <= 64; n++) begin
      apb(1'b1, rbf_pkg::OFS_TXDATA, n);
      apb(1'b0, rbf_pkg::OFS_STBYTE, 0);
      chk(rd, (n > 16) ? 15 : n - 1);
      sweep(n, 0);
    end
    apb(1'b0, rbf_pkg::OFS_TXCNT, 0);
    chk(rd, 64);
    // Draining through the link shows the falling threshold edge
    for (int n = 1; n <= 64; n++) begin
      rbf_radio_model_i.tx_byte(b);
      chk(b, n);
      @(posedge mclk);
      sweep(64 - n, 0);
    end
    rbf_radio_model_i.tx_byte(b);
    chk(b, 8'h00);
    @(posedge mclk);
    apb(1'b0, rbf_pkg::OFS_IRQ_STAT, 0);
    chk(rd[1], 1'b1);
    chk(irq, 1'b0);
    apb(1'b1, rbf_pkg::OFS_IRQ_MASK, 2);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b1);
    apb(1'b1, rbf_pkg::OFS_CTRL, 32'h200);
    repeat (3) @(posedge mclk);
    chk(pins[0], 1'b1);
    apb(1'b1, rbf_pkg::OFS_IRQ_STAT, 2);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b0);
    chk(pins[0], 1'b0);
    $display("transmit test done");
    for (int n = 1; n <= 65; n++) begin
      rbf_radio_model_i.rx_byte(8'(n));
      repeat (8) @(posedge mclk);
      apb(1'b0, rbf_pkg::OFS_RXCNT, 0);
      chk(rd, (n > 64) ? 64 : n);
      // Second poll must agree before any read is trusted
      apb(1'b0, rbf_pkg::OFS_RXCNT, 0);
      chk(rd, (n > 64) ? 64 : n);
      sweep(0, n);
    end
    apb(1'b0, rbf_pkg::OFS_IRQ_STAT, 0);
    chk(rd[0], 1'b1);
    for (int n = 1; n <= 64; n++) begin
      apb(1'b0, rbf_pkg::OFS_RXDATA, 0);
      chk(rd, (((n < 50) ? 15 : 65 - n) << 8) | n);
    end
    $display("receive test done");
    rbf_radio_model_i.rx_byte(8'h5a);
    @(posedge mclk);
    apb(1'b1, rbf_pkg::OFS_TXDATA, 8'ha5);
    repeat (8) @(posedge mclk);
    apb(1'b1, rbf_pkg::OFS_CTRL, 32'h410);
    apb(1'b0, rbf_pkg::OFS_RXCNT, 0);
    chk(rd, 32'h0);
    apb(1'b0, rbf_pkg::OFS_TXCNT, 0);
    chk(rd, 32'h0);
    $display("sleep test done");
    conclude();
  end
endmodule : testbench
